// ### include/cpp_pkg.sv
`default_nettype none
package cpp_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;
  localparam int MODE_W = 3;
  // Mode-select encodings; arbitrary assignment
  localparam logic [2:0] MODE_MASTER_SERIAL   = 3'h0;
  localparam logic [2:0] MODE_SLAVE_PARALLEL  = 3'h1;
  localparam logic [2:0] MODE_MASTER_PARALLEL = 3'h2;
  localparam logic [2:0] MODE_PERIPHERAL      = 3'h3;
  localparam logic [2:0] MODE_SLAVE_SERIAL    = 3'h7;
  localparam int CLK_MHZ = 25;
  localparam int STROBE_NS = 320;
  localparam int STROBE_HALF_CYC = (STROBE_NS * CLK_MHZ / 1000) / 2;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 20'h00000;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              valid;
  } cpp_byte_t;
endpackage : cpp_pkg
`default_nettype wire

// ### rtl/cpp_config_port.sv
`timescale 1ns/10ps
`default_nettype none
module cpp_config_port #(
  parameter int HALF_CYC = cpp_pkg::STROBE_HALF_CYC
) (
  input  wire logic                      clk_in,
  input  wire logic                      reset_n_in,
  input  wire logic                      start_in,
  input  wire logic                      finish_in,
  input  wire logic [cpp_pkg::MODE_W-1:0] config_mode_select_in,
  input  wire logic                      select_low_input_in,
  input  wire logic                      select_high_input_in,
  input  wire logic                      write_strobe_n_in,
  input  wire logic [cpp_pkg::DATA_W-1:0] data_in,
  input  wire logic                      strobe_in,
  output logic                           strobe_out,
  output logic                           strobe_oe_out,
  output logic [cpp_pkg::ADDR_W-1:0]     addr_out,
  output logic                           addr_oe_out,
  output logic                           chain_data_out,
  output logic                           chain_oe_out,
  output logic                           busy_high_out,
  output logic                           busy_low_n_out,
  output logic                           user_pins_free_out,
  output cpp_pkg::cpp_byte_t             byte_out,
  output logic                           bit_valid_out,
  output logic                           bit_out
);
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_CONFIG = 2'b01, ST_DONE = 2'b11} cpp_state_t;
  localparam int SW = cpp_pkg::MODE_W + cpp_pkg::DATA_W + 5;
  logic [SW-1:0] raw_w;
  logic [SW-1:0] sync_w;
  cpp_sync #(.W(SW)) u_sync (
    .clk_in    (clk_in),
    .reset_n_in(reset_n_in),
    .async_in  (raw_w),
    .sync_out  (sync_w)
  );
  assign raw_w = {config_mode_select_in, data_in, select_low_input_in, select_high_input_in,
                  write_strobe_n_in, strobe_in, start_in};
  logic [cpp_pkg::MODE_W-1:0] mode_s;
  logic [cpp_pkg::DATA_W-1:0] data_s;
  logic sel_lo_s, sel_hi_s, wr_n_s, strb_s, start_s;
  assign {mode_s, data_s, sel_lo_s, sel_hi_s, wr_n_s, strb_s, start_s} = sync_w;
  cpp_state_t state_q, state_d;
  logic [cpp_pkg::MODE_W-1:0] mode_q, mode_d;
  logic [cpp_pkg::ADDR_W-1:0] addr_q, addr_d;
  logic [7:0] div_q, div_d;
  logic gen_q, gen_d, strb_prev_q, strb_prev_d;
  logic [cpp_pkg::DATA_W-1:0] shift_q, shift_d;
  logic [2:0] cnt_q, cnt_d;
  logic chain_q, chain_d, pend_q, pend_d;
  cpp_pkg::cpp_byte_t byte_q, byte_d;
  logic bitv_q, bitv_d, bit_q, bit_d;
  logic master_w, parallel_w, serial_w, periph_w, sel_w, strobe_w, rise_w, fall_w, cfg_w;
  always_comb begin
    cfg_w      = (state_q == ST_CONFIG);
    master_w   = (mode_q == cpp_pkg::MODE_MASTER_SERIAL) ||
                 (mode_q == cpp_pkg::MODE_MASTER_PARALLEL);
    periph_w   = (mode_q == cpp_pkg::MODE_PERIPHERAL);
    parallel_w = periph_w || (mode_q == cpp_pkg::MODE_MASTER_PARALLEL) ||
                 (mode_q == cpp_pkg::MODE_SLAVE_PARALLEL);
    serial_w   = !parallel_w;
    sel_w      = !sel_lo_s && !wr_n_s && sel_hi_s;
    strobe_w   = master_w ? gen_q : strb_s;
    rise_w     = strobe_w && !strb_prev_q;
    fall_w     = !strobe_w && strb_prev_q;
  end
  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    addr_d = addr_q;
    div_d = div_q;
    gen_d = gen_q;
    strb_prev_d = strobe_w;
    shift_d = shift_q;
    cnt_d = cnt_q;
    chain_d = chain_q;
    pend_d = pend_q;
    byte_d = byte_q;
    byte_d.valid = 1'b0;
    bitv_d = 1'b0;
    bit_d = bit_q;
    unique case (state_q)
      ST_IDLE: begin
        if (start_s) begin
          state_d = ST_CONFIG;
          mode_d = mode_s;
          addr_d = cpp_pkg::ADDR_RESET;
          cnt_d = 3'h0;
          div_d = 8'h00;
          gen_d = 1'b0;
          // Prime edge detector to new source; an idle-high strobe must not look like a rise
          strb_prev_d = ((mode_s == cpp_pkg::MODE_MASTER_SERIAL) ||
                         (mode_s == cpp_pkg::MODE_MASTER_PARALLEL)) ? 1'b0 : strb_s;
        end
      end
      ST_CONFIG: begin
        if (finish_in) begin
          state_d = ST_DONE;
        end
        if (master_w) begin
          if (div_q >= 8'(HALF_CYC - 1)) begin
            div_d = 8'h00;
            gen_d = !gen_q;
          end else begin
            div_d = div_q + 8'h01;
          end
        end
        // Strobe on the finishing cycle is ignored, nothing captured outside config
        if (rise_w && !finish_in) begin
          if (parallel_w) begin
            if (!periph_w || sel_w) begin
              byte_d.data = data_s;
              byte_d.addr = addr_q;
              byte_d.valid = 1'b1;
              shift_d = data_s;
              pend_d = 1'b1;
              if (mode_q == cpp_pkg::MODE_MASTER_PARALLEL) begin
                addr_d = addr_q + 20'h00001;
              end
            end
          end else begin
            // Serial bit capture on bit 0
            bitv_d = 1'b1;
            bit_d = data_s[0];
            pend_d = 1'b1;
            shift_d = {shift_q[cpp_pkg::DATA_W-2:0], data_s[0]};
          end
        end
        if (fall_w && pend_q) begin
          if (serial_w) begin
            chain_d = shift_q[0];
            pend_d = 1'b0;
          end else begin
            chain_d = shift_q[cpp_pkg::DATA_W-1];
            shift_d = {shift_q[cpp_pkg::DATA_W-2:0], 1'b0};
            cnt_d = cnt_q + 3'h1;
            pend_d = (cnt_q != 3'h7);
          end
        end
      end
      ST_DONE: begin
        gen_d = 1'b0;
      end
      default: state_d = ST_IDLE;
    endcase
  end
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= ST_IDLE;
      mode_q <= 3'h0;
      addr_q <= cpp_pkg::ADDR_RESET;
      div_q <= 8'h00;
      gen_q <= 1'b0;
      strb_prev_q <= 1'b0;
      shift_q <= 8'h00;
      cnt_q <= 3'h0;
      chain_q <= 1'b0;
      pend_q <= 1'b0;
      byte_q <= '0;
      bitv_q <= 1'b0;
      bit_q <= 1'b0;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
      addr_q <= addr_d;
      div_q <= div_d;
      gen_q <= gen_d;
      strb_prev_q <= strb_prev_d;
      shift_q <= shift_d;
      cnt_q <= cnt_d;
      chain_q <= chain_d;
      pend_q <= pend_d;
      byte_q <= byte_d;
      bitv_q <= bitv_d;
      bit_q <= bit_d;
    end
  end
  assign strobe_out = gen_q;
  assign strobe_oe_out = cfg_w && master_w;
  assign addr_out = addr_q;
  assign addr_oe_out = cfg_w && (mode_q == cpp_pkg::MODE_MASTER_PARALLEL);
  assign chain_data_out = chain_q;
  assign chain_oe_out = cfg_w;
  assign busy_high_out = cfg_w;
  assign busy_low_n_out = !cfg_w;
  assign user_pins_free_out = (state_q == ST_DONE);
  assign byte_out = byte_q;
  assign bit_valid_out = bitv_q;
  assign bit_out = bit_q;
endmodule : cpp_config_port
`default_nettype wire

// ### rtl/cpp_sync.sv
`timescale 1ns/10ps
`default_nettype none
module cpp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         reset_n_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end
  assign sync_out = sync_q;
endmodule : cpp_sync
`default_nettype wire

// ### tb/cpp_config_port_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module cpp_config_port_monitor (
  input wire logic               clk_in,
  input wire logic               reset_n_in,
  input wire logic               strobe_out,
  input wire logic               strobe_oe_out,
  input wire logic               addr_oe_out,
  input wire logic               chain_data_out,
  input wire logic               chain_oe_out,
  input wire logic               busy_high_out,
  input wire logic               busy_low_n_out,
  input wire logic               user_pins_free_out,
  input wire logic [19:0]        addr_out,
  input wire cpp_pkg::cpp_byte_t byte_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  a_status_pair: assert property (busy_high_out == !busy_low_n_out)
    else $error("status pair");
  a_chain_enable: assert property (chain_oe_out == busy_high_out)
    else $error("chain enable");
  a_pins_free: assert property (user_pins_free_out |-> !busy_high_out && !strobe_oe_out)
    else $error("pins not free");
  a_addr_master: assert property (addr_oe_out |-> busy_high_out && strobe_oe_out)
    else $error("address enable");
  a_addr_step: assert property (addr_oe_out && $changed(addr_out) |-> addr_out == $past(addr_out) + 20'h1)
    else $error("address step");
  a_addr_zero: assert property ($rose(addr_oe_out) |-> addr_out == 20'h0)
    else $error("address start");
  a_byte_pulse: assert property (byte_out.valid |=> !byte_out.valid)
    else $error("byte pulse");
  a_byte_config: assert property (byte_out.valid |-> busy_high_out)
    else $error("byte outside config");
  a_chain_fall: assert property (strobe_oe_out && $changed(chain_data_out) |-> !strobe_out)
    else $error("chain on rise");
  a_strobe_half: assert property (strobe_oe_out && $changed(strobe_out) |=>
    ($stable(strobe_out) || !strobe_oe_out) [*3])
    else $error("strobe half period");
endmodule : cpp_config_port_monitor
bind cpp_config_port cpp_config_port_monitor mon (
  .clk_in            (clk_in),
  .reset_n_in        (reset_n_in),
  .strobe_out        (strobe_out),
  .strobe_oe_out     (strobe_oe_out),
  .addr_oe_out       (addr_oe_out),
  .chain_data_out    (chain_data_out),
  .chain_oe_out      (chain_oe_out),
  .busy_high_out     (busy_high_out),
  .busy_low_n_out    (busy_low_n_out),
  .user_pins_free_out(user_pins_free_out),
  .addr_out          (addr_out),
  .byte_out          (byte_out)
);
`default_nettype wire

// ### tb/cpp_far_side.sv
`timescale 1ns/10ps
`default_nettype none
module cpp_far_side (
  input  wire logic [19:0] addr_in,
  input  wire logic        addr_oe_in,
  input  wire logic [7:0]  host_in,
  output logic      [7:0]  data_out
);
  assign data_out = addr_oe_in ? (addr_in[7:0] ^ 8'ha5) : host_in;
endmodule : cpp_far_side
`default_nettype wire

// ### tb/tb_cpp_config_port.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb_cpp_config_port;
  logic clk_in = 0, reset_n_in = 0, start_in = 0, finish_in = 0, strobe_in = 0;
  logic select_low_input_in = 1, write_strobe_n_in = 1, select_high_input_in = 0;
  logic [2:0] config_mode_select_in = 0;
  logic [7:0] data_in, hd = 0;
  logic strobe_out, strobe_oe_out, addr_oe_out, chain_data_out, chain_oe_out;
  logic busy_high_out, busy_low_n_out, user_pins_free_out, bit_valid_out, bit_out;
  logic [19:0] addr_out;
  cpp_pkg::cpp_byte_t byte_out;
  logic [27:0] q[$];
  logic [31:0] r = 32'h17cd5;
  logic [2:0] ml[3] = '{cpp_pkg::MODE_SLAVE_PARALLEL, cpp_pkg::MODE_PERIPHERAL, 3'h7};
  logic [2:0] bp[3] = '{3'h5, 3'h3, 3'h0};
  int fails = 0, checked = 0, cyc = 0;
  always #20 clk_in = ~clk_in;
  cpp_far_side mem (.addr_in(addr_out), .addr_oe_in(addr_oe_out), .host_in(hd),
    .data_out(data_in));
  cpp_config_port dut (
    .clk_in               (clk_in),
    .reset_n_in           (reset_n_in),
    .start_in             (start_in),
    .finish_in            (finish_in),
    .config_mode_select_in(config_mode_select_in),
    .select_low_input_in  (select_low_input_in),
    .select_high_input_in (select_high_input_in),
    .write_strobe_n_in    (write_strobe_n_in),
    .data_in              (data_in),
    .strobe_in            (strobe_in),
    .strobe_out           (strobe_out),
    .strobe_oe_out        (strobe_oe_out),
    .addr_out             (addr_out),
    .addr_oe_out          (addr_oe_out),
    .chain_data_out       (chain_data_out),
    .chain_oe_out         (chain_oe_out),
    .busy_high_out        (busy_high_out),
    .busy_low_n_out       (busy_low_n_out),
    .user_pins_free_out   (user_pins_free_out),
    .byte_out             (byte_out),
    .bit_valid_out        (bit_valid_out),
    .bit_out              (bit_out)
  );
  function automatic logic [31:0] lfsr_next(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  task automatic give_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict
  task automatic go(logic [2:0] m);
    reset_n_in = 0;
    start_in = 0;
    config_mode_select_in = m;
    repeat (10) @(negedge clk_in);
    reset_n_in = 1;
    start_in = 1;
    repeat (4) @(negedge clk_in);
    `CHK({busy_high_out, busy_low_n_out}, 2'b10)
  endtask : go
  task automatic drain_done();
    for (int i = 0; i < 900 && q.size() > 0; i++) @(negedge clk_in);
    `CHK(q.size(), 0)
    finish_in = 1;
    @(negedge clk_in);
    finish_in = 0;
    repeat (3) @(negedge clk_in);
    `CHK({user_pins_free_out, busy_high_out, addr_oe_out, chain_oe_out}, 4'h8)
  endtask : drain_done
  // Strobe stands high between frames; the bus shows the inverse once released
  // Release falls inside the frame so the next frame never reassigns in the same step
  task automatic frame(logic [7:0] d, logic [2:0] s, logic [1:0] ce);
    hd = d;
    {select_low_input_in, write_strobe_n_in, select_high_input_in} = s;
    strobe_in = 0;
    repeat (4) @(negedge clk_in);
    if (ce[1]) `CHK(chain_data_out, ce[0])
    strobe_in = 1;
    repeat (3) @(negedge clk_in);
    hd = ~d;
    {select_low_input_in, write_strobe_n_in, select_high_input_in} = 3'h6;
    repeat (2) @(negedge clk_in);
  endtask : frame
  always @(negedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails++;
      give_verdict();
    end
    if (byte_out.valid === 1'b1 || bit_valid_out === 1'b1) begin
      if (q.size() == 0) begin
        fails++;
        $display("[ERR] %0t unexpected result", $time);
      end else `CHK(config_mode_select_in == cpp_pkg::MODE_MASTER_PARALLEL ?
        {byte_out.addr, byte_out.data} : bit_valid_out ? {27'h0, bit_out} :
        {20'h0, byte_out.data}, q.pop_front())
    end
  end
  initial begin
    logic bad, pb;
    for (int k = 0; k < 8; k++) q.push_back({k[19:0], k[7:0] ^ 8'ha5});
    go(cpp_pkg::MODE_MASTER_PARALLEL);
    `CHK({strobe_oe_out, addr_oe_out}, 2'b11)
    drain_done();
    hd = 8'h01;
    repeat (3) q.push_back(28'h1);
    go(cpp_pkg::MODE_MASTER_SERIAL);
    `CHK({strobe_oe_out, addr_oe_out}, 2'b10)
    drain_done();
    for (int i = 0; i < 3; i++) begin
      go(ml[i]);
      `CHK(strobe_oe_out, 1'b0)
      for (int k = 0; k < 12; k++) begin
        r = lfsr_next(r);
        bad = (i == 1) && r[8];
        if (!bad) q.push_back(i == 2 ? {27'h0, r[0]} : {20'h0, r[7:0]});
        frame(r[7:0], bad ? bp[r[10:9] % 3] : 3'h1, {(i == 2) && (k > 0), pb});
        pb = r[0];
      end
      drain_done();
    end
    give_verdict();
  end
endmodule : tb_cpp_config_port
`default_nettype wire
